/* File: bench/fsc_fan_model.sv */
`timescale 1ns/1ns
`default_nettype none

module fsc_fan_model #(
  parameter int HALF_CYC = 5,
  parameter int SPIN_DOWN_CYC = 1000
) (
  input wire logic clk_i,
  input wire logic pwm_i,
  output logic tach_o
);
  int idle_cnt = SPIN_DOWN_CYC;
  int ph_cnt = 0;
  logic spin;

  // ----------------------------------------
  // rotor: spins while drive seen lately
  // ----------------------------------------
  assign spin = (idle_cnt < SPIN_DOWN_CYC);

  always_ff @(posedge clk_i) begin
    if (pwm_i === 1'b1) begin
      idle_cnt <= 0;
    end else if (spin) begin
      idle_cnt <= idle_cnt + 1;
    end
    if (spin) begin
      ph_cnt <= (ph_cnt == 2 * HALF_CYC - 1) ? 0 : ph_cnt + 1;
    end
  end

  // open collector with pull-up: high when stopped
  assign tach_o = spin ? (ph_cnt < HALF_CYC) : 1'b1;
endmodule // fsc_fan_model

`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fsc_defines.svh"

module testbench
  import fsc_pkg::*;
;
  logic sys_clk, rst_n, psel, penable, pwrite;
  logic [7:0] paddr, t_cpu, t_hub, t_mod;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  wire logic [1:0] tach, pwm;
  int failures = 0;
  int total_checks = 0;

  fsc_top #(.TACH_GATE_CYC(200)) u_dut (
    .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TEMP_CPU_I(t_cpu),
    .TEMP_HUB_I(t_hub), .TEMP_MOD_I(t_mod), .FAN_TACH_I(tach),
    .FAN_PWM_O(pwm)
  );
  fsc_fan_model u_fan0 (.clk_i(sys_clk), .pwm_i(pwm[0]), .tach_o(tach[0]));
  fsc_fan_model u_fan1 (.clk_i(sys_clk), .pwm_i(pwm[1]), .tach_o(tach[1]));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp, input logic eer);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
    chk32(d & m, exp);
    chk32({31'h0, e}, {31'h0, eer});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic eer);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk32({31'h0, e}, {31'h0, eer});
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m,
      input logic [1:0] s, input logic [2:0] p, input logic [6:0] man,
      input logic [7:0] tr, input logic [6:0] ts);
    ctl = {1'b0, ts, tr, 1'b0, man, 1'b0, p, s, m};
  endfunction

  // counts drive-high cycles of both channels over one period
  // sampled mid-cycle, where the registered drive has settled
  task automatic meas(input int d0, input int d1);
    int h0, h1;
    h0 = 0;
    h1 = 0;
    repeat (800) begin
      @(negedge sys_clk);
      h0 += (pwm[0] === 1'b1);
      h1 += (pwm[1] === 1'b1);
    end
    @(posedge sys_clk);
    chk32(h0, d0 * 8);
    chk32(h1, d1 * 8);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_and_map();
    rd(`FSC_ADDR_CH0_CTRL, 32'hFFFF_FFFF, 32'h3232_322A, 1'b0);
    rd(`FSC_ADDR_CH1_CTRL, 32'hFFFF_FFFF, 32'h3232_322A, 1'b0);
    rd(`FSC_ADDR_MAX_JUNCTION_TEMPERATURE, 32'hFFFF_FFFF, 32'h0000_0064,
       1'b0);
    rd(8'h18, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    rd(8'h02, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    wr(`FSC_ADDR_TEMPS, 32'h0011_2233, 1'b1);
    wr(`FSC_ADDR_CH0_STAT, 32'h0000_1234, 1'b1);
    rd(`FSC_ADDR_TEMPS, 32'hFFFF_FFFF, 32'h0033_212A, 1'b0);
    $display("test reset_and_map done");
  endtask

  task automatic t_tach();
    wr(`FSC_ADDR_CH0_CTRL, ctl(FSC_MODE_MANUAL, FSC_SRC_CPU, 3'h1,
       7'h3C, 8'h32, 7'h32), 1'b0);
    repeat (1700) @(posedge sys_clk);
    for (int p = 1; p <= 4; p++) begin
      wr(`FSC_ADDR_CH0_CTRL, ctl(FSC_MODE_MANUAL, FSC_SRC_CPU, p[2:0],
         7'h3C, 8'h32, 7'h32), 1'b0);
      repeat (450) @(posedge sys_clk);
      rd(`FSC_ADDR_CH0_STAT, 32'h0000_FFFF, 32'((20 * 60) / p),
         1'b0);
    end
    rd(`FSC_ADDR_CH1_STAT, 32'h0000_FFFF, 32'h0000_0258, 1'b0);
    $display("test tach done");
  endtask

  task automatic t_manual_off();
    wr(`FSC_ADDR_CH0_CTRL, ctl(FSC_MODE_MANUAL, FSC_SRC_CPU, 3'h2,
       7'h32, 8'h32, 7'h32), 1'b0);
    wr(`FSC_ADDR_CH1_CTRL, ctl(FSC_MODE_MANUAL, FSC_SRC_CPU, 3'h2,
       7'h19, 8'h32, 7'h32), 1'b0);
    repeat (1700) @(posedge sys_clk);
    meas(50, 25);
    t_cpu <= 8'h5F;
    repeat (1700) @(posedge sys_clk);
    meas(50, 25);
    rd(`FSC_ADDR_CH1_STAT, 32'h007F_0000, 32'h0019_0000, 1'b0);
    wr(`FSC_ADDR_CH0_CTRL, 32'h0000_3200, 1'b0);
    repeat (2) @(posedge sys_clk);
    meas(0, 25);
    rd(`FSC_ADDR_CH0_STAT, 32'h007F_0000, 32'h0000_0000, 1'b0);
    $display("test manual_off done");
  endtask

  task automatic t_auto();
    logic [1:0] src [6] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
    logic [7:0] tc [6] = '{8'h28, 8'h46, 8'h5A, 8'h28, 8'h28, 8'h46};
    logic [7:0] th [6] = '{8'h5A, 8'h5A, 8'h14, 8'h50, 8'h5A, 8'h14};
    logic [7:0] tm [6] = '{8'h5A, 8'h14, 8'h5A, 8'h5A, 8'h3C, 8'h14};
    logic [7:0] tj [6] = '{8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h50};
    int ed [6] = '{50, 75, 100, 87, 62, 100};
    for (int i = 0; i < 6; i++) begin
      t_cpu <= tc[i];
      t_hub <= th[i];
      t_mod <= tm[i];
      wr(`FSC_ADDR_MAX_JUNCTION_TEMPERATURE, {24'h0, tj[i]}, 1'b0);
      wr(`FSC_ADDR_CH0_CTRL, ctl(FSC_MODE_AUTO, src[i], 3'h2,
         7'h00, 8'h32, 7'h32), 1'b0);
      wr(`FSC_ADDR_CH1_CTRL, ctl(FSC_MODE_AUTO, src[i], 3'h2,
         7'h00, 8'h32, 7'h32), 1'b0);
      repeat (1700) @(posedge sys_clk);
      meas(ed[i], ed[i]);
      rd(`FSC_ADDR_CH0_STAT, 32'h007F_0000, 32'(ed[i]) << 16, 1'b0);
    end
    wr(`FSC_ADDR_MAX_JUNCTION_TEMPERATURE, 32'h0000_0064, 1'b0);
    $display("test auto done");
  endtask

  task automatic t_clamp();
    wr(`FSC_ADDR_CH1_CTRL, 32'h0A0A_7F70, 1'b0);
    rd(`FSC_ADDR_CH1_CTRL, 32'hFFFF_FFFF, 32'h1E14_6440, 1'b0);
    wr(`FSC_ADDR_CH1_CTRL, 32'h0000_0000, 1'b0);
    rd(`FSC_ADDR_CH1_CTRL, 32'hFFFF_FFFF, 32'h1E14_0010, 1'b0);
    wr(`FSC_ADDR_CH1_CTRL, 32'h7FFF_0020, 1'b0);
    rd(`FSC_ADDR_CH1_CTRL, 32'hFFFF_FFFF, 32'h6450_0020, 1'b0);
    pstrb <= 4'h1;
    wr(`FSC_ADDR_CH1_CTRL, 32'hFFFF_FF35, 1'b0);
    rd(`FSC_ADDR_CH1_CTRL, 32'hFFFF_FFFF, 32'h6450_0035, 1'b0);
    pstrb <= 4'hF;
    wr(`FSC_ADDR_CH1_CTRL, 32'h0000_001F, 1'b0);
    rd(`FSC_ADDR_CH1_CTRL, 32'hFFFF_FFFF, 32'h1E14_0018, 1'b0);
    $display("test clamp done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    t_cpu = 8'h2A;
    t_hub = 8'h21;
    t_mod = 8'h33;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_and_map();
    t_tach();
    t_manual_off();
    t_auto();
    t_clamp();
    end_of_test();
  end
endmodule // testbench

`default_nettype wire

/* File: design/fsc_defines.svh */
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define FSC_ADDR_CH0_CTRL 8'h00
`define FSC_ADDR_CH1_CTRL 8'h04
`define FSC_ADDR_MAX_JUNCTION_TEMPERATURE 8'h08
`define FSC_ADDR_TEMPS 8'h0C
`define FSC_ADDR_CH0_STAT 8'h10
`define FSC_ADDR_CH1_STAT 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define FSC_CTRL_MODE_LSB 0
`define FSC_CTRL_SRC_LSB 2
`define FSC_CTRL_PPR_LSB 4
`define FSC_CTRL_MAN_LSB 8
`define FSC_CTRL_TRIP_LSB 16
`define FSC_CTRL_TSPD_LSB 24
`define FSC_TEMPS_CPU_LSB 0
`define FSC_TEMPS_HUB_LSB 8
`define FSC_TEMPS_MOD_LSB 16
`define FSC_STAT_RPM_LSB 0
`define FSC_STAT_DUTY_LSB 16

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define FSC_RST_MODE 2'h2
`define FSC_RST_SRC 2'h2
`define FSC_RST_PPR 3'h2
`define FSC_PPR_MIN 3'h1
`define FSC_PPR_MAX 3'h4
`define FSC_RST_MANUAL 7'h32
`define FSC_RST_TRIP 8'h32
`define FSC_TRIP_MIN 8'h14
`define FSC_TRIP_MAX 8'h50
`define FSC_RST_TSPD 7'h32
`define FSC_TSPD_MIN 7'h1E
`define FSC_DUTY_FULL 7'h64
`define FSC_RST_MAX_JUNCTION_TEMPERATURE 8'h64
`define FSC_FULL_OFFSET 8'h0A
`define FSC_RPM_SAT 16'hFFFF

// ----------------------------------------
// timing
// ----------------------------------------
`define FSC_CLK_PERIOD_NS 50
`define FSC_PWM_PERIOD_NS 40000
`define FSC_PWM_STEP_CYC ((`FSC_PWM_PERIOD_NS / `FSC_CLK_PERIOD_NS) / 100)
`define FSC_TACH_GATE_NS 1000000000
`define FSC_TACH_GATE_CYC (`FSC_TACH_GATE_NS / `FSC_CLK_PERIOD_NS)

`endif

/* File: design/fsc_pkg.sv */
package fsc_pkg;

  typedef enum logic [1:0] {
    FSC_MODE_OFF,
    FSC_MODE_MANUAL,
    FSC_MODE_AUTO
  } fsc_mode_t;

  typedef enum logic [1:0] {
    FSC_SRC_HUB,
    FSC_SRC_MODULE,
    FSC_SRC_CPU
  } fsc_src_t;

  typedef struct packed {
    fsc_mode_t mode;
    fsc_src_t src;
    logic [2:0] ppr;
    logic [6:0] manual;
    logic [7:0] trip;
    logic [6:0] tspd;
  } fsc_cfg_t;

  typedef struct packed {
    logic [7:0] cpu;
    logic [7:0] hub;
    logic [7:0] module_t;
  } fsc_temps_t;

endpackage

/* File: design/fsc_pwm.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fsc_defines.svh"

module fsc_pwm
  import fsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire fsc_cfg_t cfg_i,
  input wire fsc_temps_t temps_i,
  input wire logic [7:0] max_junction_temperature_i,
  output logic pwm_o,
  output logic [6:0] duty_o
);

  typedef struct packed {
    logic [3:0] div;
    logic [6:0] phase;
    logic [6:0] duty;
    logic pwm;
  } fsc_pwm_st_t;

  localparam fsc_pwm_st_t RST_ST = '{4'h0, 7'h00, 7'h00, 1'b0};
  localparam logic [3:0] STEP_LAST = 4'(`FSC_PWM_STEP_CYC - 1);
  localparam logic [6:0] PHASE_LAST = `FSC_DUTY_FULL - 7'h01;

  fsc_pwm_st_t st;
  fsc_pwm_st_t next_st;
  logic wrap;
  logic [7:0] temp;
  logic [7:0] full_t;
  logic [6:0] target;
  logic [15:0] prod;
  logic [15:0] quot;

  assign wrap = (st.div == STEP_LAST) && (st.phase == PHASE_LAST);

  // ----------------------------------------
  // duty target
  // ----------------------------------------
  always_comb begin
    prod = 16'h0000;
    quot = 16'h0000;
    case (cfg_i.src)
      FSC_SRC_HUB: temp = temps_i.hub;
      FSC_SRC_MODULE: temp = temps_i.module_t;
      default: temp = temps_i.cpu;
    endcase
    full_t = (max_junction_temperature_i > `FSC_FULL_OFFSET)
             ? max_junction_temperature_i - `FSC_FULL_OFFSET : 8'h00;
    if (temp >= full_t) begin
      target = `FSC_DUTY_FULL;
    end else if (temp <= cfg_i.trip) begin
      target = cfg_i.tspd;
    end else begin
      // linear ramp, span is nonzero here
      prod = {9'h000, `FSC_DUTY_FULL - cfg_i.tspd} *
             {8'h00, temp - cfg_i.trip};
      quot = prod / {8'h00, full_t - cfg_i.trip};
      target = cfg_i.tspd + quot[6:0];
    end
  end

  // ----------------------------------------
  // pwm generator
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (st.div == STEP_LAST) begin
      next_st.div = 4'h0;
      next_st.phase = (st.phase == PHASE_LAST) ? 7'h00 : st.phase + 7'h01;
    end else begin
      next_st.div = st.div + 4'h1;
    end
    if (wrap) begin
      case (cfg_i.mode)
        FSC_MODE_MANUAL: next_st.duty = cfg_i.manual;
        FSC_MODE_AUTO: next_st.duty = target;
        default: next_st.duty = 7'h00;
      endcase
    end
    if (cfg_i.mode == FSC_MODE_OFF) begin
      next_st.duty = 7'h00;
    end
    next_st.pwm = (next_st.phase < next_st.duty) &&
                  (cfg_i.mode != FSC_MODE_OFF);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  assign pwm_o = st.pwm;
  assign duty_o = st.duty;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  off_stops_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_i.mode == FSC_MODE_OFF |=> !pwm_o && duty_o == 7'h00)
    else $error("fan still driven in off mode");

  manual_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wrap && cfg_i.mode == FSC_MODE_MANUAL |=>
    duty_o == $past(cfg_i.manual))
    else $error("manual duty not applied");

  auto_full_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wrap && cfg_i.mode == FSC_MODE_AUTO && temp >= full_t |=>
    duty_o == `FSC_DUTY_FULL)
    else $error("no full speed near junction limit");

  auto_trip_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wrap && cfg_i.mode == FSC_MODE_AUTO && temp <= cfg_i.trip &&
    temp < full_t |=> duty_o == $past(cfg_i.tspd))
    else $error("trip speed not applied below trip");

  auto_ramp_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wrap && cfg_i.mode == FSC_MODE_AUTO && temp > cfg_i.trip &&
    temp < full_t |=> duty_o >= $past(cfg_i.tspd) &&
    duty_o < `FSC_DUTY_FULL)
    else $error("ramp duty out of range");

endmodule // fsc_pwm

`default_nettype wire

/* File: design/fsc_tach.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fsc_defines.svh"

module fsc_tach #(
  parameter int GATE_CYC = `FSC_TACH_GATE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tach_i,
  input wire logic [2:0] ppr_i,
  output logic [15:0] rpm_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [31:0] gate;
    logic [15:0] edges;
    logic [15:0] rpm;
  } fsc_tach_st_t;

  // sync stages reset to idle high: no false edge after reset
  localparam fsc_tach_st_t RST_ST = '{1'b1, 1'b1, 1'b1, 32'h0, 16'h0, 16'h0};
  localparam logic [31:0] GATE_LAST = 32'(GATE_CYC - 1);

  fsc_tach_st_t st;
  fsc_tach_st_t next_st;
  logic rise;
  logic [21:0] revs;

  assign rise = st.s2 && !st.s3;

  // ----------------------------------------
  // gated edge count
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = tach_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // edges times sixty, per minute
    revs = ({st.edges, 6'h00} - {4'h0, st.edges, 2'h0}) / {19'h0, ppr_i};
    if (st.gate == GATE_LAST) begin
      next_st.gate = 32'h0;
      next_st.edges = {15'h0, rise};
      next_st.rpm = (revs[21:16] != 6'h00) ? `FSC_RPM_SAT
                                           : revs[15:0];
    end else begin
      next_st.gate = st.gate + 32'h1;
      if (rise && st.edges != 16'hFFFF) begin
        next_st.edges = st.edges + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  assign rpm_o = st.rpm;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  edge_count_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rise && st.gate != GATE_LAST && st.edges < 16'h0010 |=>
    st.edges == $past(st.edges) + 16'h1)
    else $error("tachometer edge missed");

  rpm_scale_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    st.gate == GATE_LAST && st.edges[15:8] == 8'h00 |=>
    rpm_o == ($past(st.edges) * 16'h003C) / {13'h0, $past(ppr_i)})
    else $error("speed not scaled by pulses per turn");

endmodule // fsc_tach

`default_nettype wire

/* File: design/fsc_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fsc_defines.svh"

// Function
// - off mode stops the fan output completely, duty zero
// - manual mode drives a fixed configured duty, ignoring temperature
// - auto mode regulates duty from temperature with no software help
// - pulses per revolution configurable one to four, default two
// - trip point 20 to 80 degrees, default 50
// - speed at trip point at least 30 percent, default 50
// - auto full speed at ten below maximum junction temperature
// - auto source chosen from hub, module or processor sensor
// - second independent channel for the external fan, same settings
// - processor, hub and module temperatures readable in degrees Celsius
module fsc_top
  import fsc_pkg::*;
#(
  parameter int TACH_GATE_CYC = `FSC_TACH_GATE_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] TEMP_CPU_I,
  input wire logic [7:0] TEMP_HUB_I,
  input wire logic [7:0] TEMP_MOD_I,
  input wire logic [1:0] FAN_TACH_I,
  output logic [1:0] FAN_PWM_O
);

  typedef struct packed {
    fsc_cfg_t [1:0] cfg;
    logic [7:0] max_junction_temperature;
    logic [31:0] prdata;
    logic pslverr;
  } fsc_top_st_t;

  localparam fsc_cfg_t RST_CFG = '{
    fsc_mode_t'(`FSC_RST_MODE), fsc_src_t'(`FSC_RST_SRC), `FSC_RST_PPR,
    `FSC_RST_MANUAL, `FSC_RST_TRIP, `FSC_RST_TSPD};
  localparam fsc_top_st_t RST_ST = '{
    {RST_CFG, RST_CFG}, `FSC_RST_MAX_JUNCTION_TEMPERATURE, 32'h0, 1'b0};
  localparam logic [7:0] CTRL_ADDR [2] = '{
    `FSC_ADDR_CH0_CTRL, `FSC_ADDR_CH1_CTRL};
  localparam logic [7:0] STAT_ADDR [2] = '{
    `FSC_ADDR_CH0_STAT, `FSC_ADDR_CH1_STAT};

  fsc_top_st_t st;
  fsc_top_st_t next_st;
  fsc_temps_t temps;
  logic [6:0] duty [2];
  logic [15:0] rpm [2];
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic setup;
  logic access;

  assign setup = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I;
  assign temps = '{TEMP_CPU_I, TEMP_HUB_I, TEMP_MOD_I};

  // ----------------------------------------
  // field helpers
  // ----------------------------------------
  function automatic logic [31:0] pack_cfg(input fsc_cfg_t c);
    logic [31:0] w;
    w = 32'h0;
    w[`FSC_CTRL_MODE_LSB +: 2] = c.mode;
    w[`FSC_CTRL_SRC_LSB +: 2] = c.src;
    w[`FSC_CTRL_PPR_LSB +: 3] = c.ppr;
    w[`FSC_CTRL_MAN_LSB +: 7] = c.manual;
    w[`FSC_CTRL_TRIP_LSB +: 8] = c.trip;
    w[`FSC_CTRL_TSPD_LSB +: 7] = c.tspd;
    return w;
  endfunction

  function automatic fsc_cfg_t unpack_cfg(input logic [31:0] w);
    fsc_cfg_t c;
    logic [2:0] ppr;
    logic [7:0] trip;
    logic [6:0] tspd;
    logic [6:0] man;
    c = RST_CFG;
    ppr = w[`FSC_CTRL_PPR_LSB +: 3];
    trip = w[`FSC_CTRL_TRIP_LSB +: 8];
    tspd = w[`FSC_CTRL_TSPD_LSB +: 7];
    man = w[`FSC_CTRL_MAN_LSB +: 7];
    // unknown mode code falls back to off
    c.mode = (w[`FSC_CTRL_MODE_LSB +: 2] == 2'h3) ? FSC_MODE_OFF
             : fsc_mode_t'(w[`FSC_CTRL_MODE_LSB +: 2]);
    c.src = (w[`FSC_CTRL_SRC_LSB +: 2] == 2'h3) ? FSC_SRC_CPU
            : fsc_src_t'(w[`FSC_CTRL_SRC_LSB +: 2]);
    c.ppr = (ppr < `FSC_PPR_MIN) ? `FSC_PPR_MIN
            : (ppr > `FSC_PPR_MAX) ? `FSC_PPR_MAX : ppr;
    c.trip = (trip < `FSC_TRIP_MIN) ? `FSC_TRIP_MIN
             : (trip > `FSC_TRIP_MAX) ? `FSC_TRIP_MAX : trip;
    c.tspd = (tspd < `FSC_TSPD_MIN) ? `FSC_TSPD_MIN
             : (tspd > `FSC_DUTY_FULL) ? `FSC_DUTY_FULL : tspd;
    c.manual = (man > `FSC_DUTY_FULL) ? `FSC_DUTY_FULL : man;
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] w;
    w = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        w[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return w;
  endfunction

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    for (int c = 0; c < 2; c++) begin
      if (PADDR_I == CTRL_ADDR[c]) begin
        rd_word = pack_cfg(st.cfg[c]);
        rd_hit = 1'b1;
        wr_hit = 1'b1;
      end
      if (PADDR_I == STAT_ADDR[c]) begin
        rd_word[`FSC_STAT_RPM_LSB +: 16] = rpm[c];
        rd_word[`FSC_STAT_DUTY_LSB +: 7] = duty[c];
        rd_hit = 1'b1;
      end
    end
    if (PADDR_I == `FSC_ADDR_MAX_JUNCTION_TEMPERATURE) begin
      rd_word[7:0] = st.max_junction_temperature;
      rd_hit = 1'b1;
      wr_hit = 1'b1;
    end
    if (PADDR_I == `FSC_ADDR_TEMPS) begin
      rd_word[`FSC_TEMPS_CPU_LSB +: 8] = temps.cpu;
      rd_word[`FSC_TEMPS_HUB_LSB +: 8] = temps.hub;
      rd_word[`FSC_TEMPS_MOD_LSB +: 8] = temps.module_t;
      rd_hit = 1'b1;
    end
  end

  // ----------------------------------------
  // register update
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // answer is prepared in setup, shown in access
    if (setup) begin
      next_st.prdata = PWRITE_I ? 32'h0 : rd_word;
      next_st.pslverr = PWRITE_I ? !wr_hit : !rd_hit;
    end
    if (access && PWRITE_I) begin
      for (int c = 0; c < 2; c++) begin
        if (PADDR_I == CTRL_ADDR[c]) begin
          next_st.cfg[c] = unpack_cfg(merge(pack_cfg(st.cfg[c]), PWDATA_I,
                                            PSTRB_I));
        end
      end
      if (PADDR_I == `FSC_ADDR_MAX_JUNCTION_TEMPERATURE && PSTRB_I[0]) begin
        next_st.max_junction_temperature = PWDATA_I[7:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA_O = st.prdata;
  assign PSLVERR_O = st.pslverr;
  assign PREADY_O = 1'b1;

  // ----------------------------------------
  // fan channels
  // ----------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    fsc_pwm u_pwm (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .cfg_i(st.cfg[c]),
      .temps_i(temps),
      .max_junction_temperature_i(st.max_junction_temperature),
      .pwm_o(FAN_PWM_O[c]),
      .duty_o(duty[c])
    );
    fsc_tach #(
      .GATE_CYC(TACH_GATE_CYC)
    ) u_tach (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .tach_i(FAN_TACH_I[c]),
      .ppr_i(st.cfg[c].ppr),
      .rpm_o(rpm[c])
    );
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  unmapped_err_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    setup && !PWRITE_I && !rd_hit |=> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped read not flagged");

  temp_read_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    setup && !PWRITE_I && PADDR_I == `FSC_ADDR_TEMPS |=>
    PRDATA_O[7:0] == $past(TEMP_CPU_I) &&
    PRDATA_O[15:8] == $past(TEMP_HUB_I) &&
    PRDATA_O[23:16] == $past(TEMP_MOD_I))
    else $error("temperature readout wrong");

  trip_range_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    access && PWRITE_I && PADDR_I == `FSC_ADDR_CH0_CTRL && PSTRB_I[2] |=>
    st.cfg[0].trip >= `FSC_TRIP_MIN && st.cfg[0].trip <= `FSC_TRIP_MAX)
    else $error("trip point out of range");

  ppr_range_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    access && PWRITE_I && PADDR_I == `FSC_ADDR_CH0_CTRL && PSTRB_I[0] |=>
    st.cfg[0].ppr >= `FSC_PPR_MIN && st.cfg[0].ppr <= `FSC_PPR_MAX)
    else $error("pulse count out of range");

  tspd_min_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    access && PWRITE_I && PADDR_I == `FSC_ADDR_CH1_CTRL && PSTRB_I[3] |=>
    st.cfg[1].tspd >= `FSC_TSPD_MIN)
    else $error("trip speed below minimum");

  ch_indep_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    access && PWRITE_I && PADDR_I == `FSC_ADDR_CH0_CTRL |=>
    st.cfg[1] == $past(st.cfg[1]))
    else $error("channel write leaked into other channel");

endmodule // fsc_top

`default_nettype wire
